/* include/oms_defs.svh */
// constants for the oscillator mode select block
// assumes inclusion by the package and the block source only
`ifndef OMS_DEFS_SVH
`define OMS_DEFS_SVH
`define OMS_MODE_W 3
`define OMS_CODE_LP 3'h0
`define OMS_CODE_XT 3'h1
`define OMS_CODE_HS 3'h2
`define OMS_CODE_EC 3'h3
`define OMS_CODE_INT_GPIO 3'h4
`define OMS_CODE_INT_CLKOUT 3'h5
`define OMS_CODE_RC_GPIO 3'h6
`define OMS_CODE_RC_CLKOUT 3'h7
`define OMS_SYS_CLK_KHZ 125000
`define OMS_INTERNAL_KHZ 8000
`define OMS_CLKOUT_DIV 4
`define OMS_HS_ADVISED_KHZ 3500
`endif

/* include/oms_pkg.sv */
// types for the oscillator mode select block
// assumes oms_defs.svh is on the include path
`include "oms_defs.svh"
package oms_pkg;
  typedef enum logic [2:0] {
    low_power_crystal_mode = `OMS_CODE_LP,
    crystal_resonator_mode = `OMS_CODE_XT,
    high_speed_crystal_mode = `OMS_CODE_HS,
    external_clock_gpio_mode = `OMS_CODE_EC,
    internal_osc_dual_gpio_mode = `OMS_CODE_INT_GPIO,
    internal_osc_clkout_mode = `OMS_CODE_INT_CLKOUT,
    resistor_capacitor_gpio_mode = `OMS_CODE_RC_GPIO,
    resistor_capacitor_clkout_mode = `OMS_CODE_RC_CLKOUT
  } oms_mode_type;

  typedef enum logic [1:0] {
    oms_src_crystal = 2'h0,
    oms_src_rc = 2'h1,
    oms_src_internal = 2'h2,
    oms_src_external = 2'h3
  } oms_src_type;

  // pin ownership and drive seen by the port a logic
  typedef struct packed {
    logic osc_in_reserved;
    logic osc_out_reserved;
    logic bit6_gpio;
    logic bit7_gpio;
    logic bit6_clkout;
  } oms_pins_type;
endpackage : oms_pkg

/* src/oms_select.sv */
// oscillator mode decode, pin ownership and clock/4 output
// assumes osc_mode_select_bits are static straps, sampled after reset release
`timescale 1ns/100ps
`default_nettype none
`include "oms_defs.svh"
module oms_select #(
  parameter int clkout_div = `OMS_CLKOUT_DIV
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [`OMS_MODE_W-1:0] osc_mode_select_bits,
  input wire logic osc_in_pin,
  output oms_pkg::oms_mode_type mode,
  output oms_pkg::oms_src_type clk_source,
  output oms_pkg::oms_pins_type pins,
  output logic sys_clk_en,
  output logic port_a_bit6_pin_out,
  output logic port_a_bit6_pin_oe,
  output logic mode_valid
);
  import oms_pkg::*;

  typedef struct packed {
    logic [1:0] sync_q;
    logic [`OMS_MODE_W-1:0] strap_s1_q;
    logic [`OMS_MODE_W-1:0] strap_s2_q;
    logic [1:0] ext_sync_q;
    logic ext_prev_q;
    logic taken_q;
    oms_mode_type mode_q;
    oms_src_type src_q;
    oms_pins_type pins_q;
    logic [7:0] int_cnt_q;
    logic [7:0] div_q;
    logic en_q;
    logic clko_q;
    logic oe_q;
    logic out_q;
  } oms_state_type;

  oms_state_type s_q;
  oms_state_type s_d;

  // every field written per mode so the pin map reads as a table
  function automatic oms_pins_type pins_of(input oms_mode_type m);
    oms_pins_type p;
    p = '0;
    case (m)
      low_power_crystal_mode: begin
        p.osc_in_reserved = 1'b1;
        p.osc_out_reserved = 1'b1;
        p.bit6_gpio = 1'b0;
        p.bit7_gpio = 1'b0;
        p.bit6_clkout = 1'b0;
      end

      crystal_resonator_mode: begin
        p.osc_in_reserved = 1'b1;
        p.osc_out_reserved = 1'b1;
        p.bit6_gpio = 1'b0;
        p.bit7_gpio = 1'b0;
        p.bit6_clkout = 1'b0;
      end

      high_speed_crystal_mode: begin
        p.osc_in_reserved = 1'b1;
        p.osc_out_reserved = 1'b1;
        p.bit6_gpio = 1'b0;
        p.bit7_gpio = 1'b0;
        p.bit6_clkout = 1'b0;
      end

      resistor_capacitor_clkout_mode: begin
        p.osc_in_reserved = 1'b1;
        p.osc_out_reserved = 1'b0;
        p.bit6_gpio = 1'b0;
        p.bit7_gpio = 1'b0;
        p.bit6_clkout = 1'b1;
      end

      resistor_capacitor_gpio_mode: begin
        p.osc_in_reserved = 1'b1;
        p.osc_out_reserved = 1'b0;
        p.bit6_gpio = 1'b1;
        p.bit7_gpio = 1'b0;
        p.bit6_clkout = 1'b0;
      end

      internal_osc_clkout_mode: begin
        p.osc_in_reserved = 1'b0;
        p.osc_out_reserved = 1'b0;
        p.bit6_gpio = 1'b0;
        p.bit7_gpio = 1'b1;
        p.bit6_clkout = 1'b1;
      end

      internal_osc_dual_gpio_mode: begin
        p.osc_in_reserved = 1'b0;
        p.osc_out_reserved = 1'b0;
        p.bit6_gpio = 1'b1;
        p.bit7_gpio = 1'b1;
        p.bit6_clkout = 1'b0;
      end

      external_clock_gpio_mode: begin
        p.osc_in_reserved = 1'b1;
        p.osc_out_reserved = 1'b0;
        p.bit6_gpio = 1'b1;
        p.bit7_gpio = 1'b0;
        p.bit6_clkout = 1'b0;
      end
      default: p = '0;
    endcase
    return p;
  endfunction : pins_of

  function automatic oms_src_type src_of(input oms_mode_type m);
    case (m)
      low_power_crystal_mode: src_of = oms_src_crystal;
      crystal_resonator_mode: src_of = oms_src_crystal;
      high_speed_crystal_mode: src_of = oms_src_crystal;
      resistor_capacitor_clkout_mode: src_of = oms_src_rc;
      resistor_capacitor_gpio_mode: src_of = oms_src_rc;
      internal_osc_clkout_mode: src_of = oms_src_internal;
      internal_osc_dual_gpio_mode: src_of = oms_src_internal;
      external_clock_gpio_mode: src_of = oms_src_external;
      default: src_of = oms_src_crystal;
    endcase
  endfunction : src_of

  // strap codes are total: every value names a mode, no cast needed
  function automatic oms_mode_type mode_of(input logic [`OMS_MODE_W-1:0] b);
    case (b)
      `OMS_CODE_LP: mode_of = low_power_crystal_mode;
      `OMS_CODE_XT: mode_of = crystal_resonator_mode;
      `OMS_CODE_HS: mode_of = high_speed_crystal_mode;
      `OMS_CODE_EC: mode_of = external_clock_gpio_mode;
      `OMS_CODE_INT_GPIO: mode_of = internal_osc_dual_gpio_mode;
      `OMS_CODE_INT_CLKOUT: mode_of = internal_osc_clkout_mode;
      `OMS_CODE_RC_GPIO: mode_of = resistor_capacitor_gpio_mode;
      `OMS_CODE_RC_CLKOUT: mode_of = resistor_capacitor_clkout_mode;
      default: mode_of = low_power_crystal_mode;
    endcase
  endfunction : mode_of

  // internal source is modelled as a rate enable off the system clock
  localparam int int_div = `OMS_SYS_CLK_KHZ / `OMS_INTERNAL_KHZ;
  localparam logic [7:0] int_last = 8'(int_div - 1);
  localparam logic [7:0] q_last = 8'(clkout_div / 2 - 1);

  logic int_tick;
  logic ext_rise;
  logic src_tick;

  // free-running, so the internal rate has no phase tie to capture
  assign int_tick = (s_q.int_cnt_q == int_last);
  assign ext_rise = s_q.ext_sync_q[1] && !s_q.ext_prev_q;

  always_comb begin
    case (s_q.src_q)
      oms_src_internal: src_tick = int_tick;
      oms_src_external: src_tick = ext_rise;
      // crystal and rc oscillators sit outside; run at the system rate
      default: src_tick = 1'b1;
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.sync_q = {s_q.sync_q[0], 1'b1};
    // strap is a pin: two flops before the decode reads it
    s_d.strap_s1_q = osc_mode_select_bits;
    s_d.strap_s2_q = s_q.strap_s1_q;
    s_d.ext_sync_q = {s_q.ext_sync_q[0], osc_in_pin};
    s_d.ext_prev_q = s_q.ext_sync_q[1];
    s_d.int_cnt_q = int_tick ? 8'h00 : s_q.int_cnt_q + 8'h01;

    // field caught once, three cycles after release, never again
    if (!s_q.taken_q && s_q.sync_q[1]) begin
      s_d.taken_q = 1'b1;
      s_d.mode_q = mode_of(s_q.strap_s2_q);
      s_d.src_q = src_of(mode_of(s_q.strap_s2_q));
      s_d.pins_q = pins_of(mode_of(s_q.strap_s2_q));
    end

    s_d.en_q = s_q.taken_q && src_tick;
    s_d.oe_q = s_q.taken_q && s_q.pins_q.bit6_clkout;
    if (s_q.taken_q && src_tick) begin
      // half period of clkout_div/2 source cycles gives source/4
      if (s_q.div_q == q_last) begin
        s_d.div_q = 8'h00;
        s_d.clko_q = !s_q.clko_q;
      end else begin
        s_d.div_q = s_q.div_q + 8'h01;
      end
    end

    // registered so the pin sees no gate glitch
    s_d.out_q = s_d.clko_q && s_d.oe_q;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign mode = s_q.mode_q;
  assign clk_source = s_q.src_q;
  assign pins = s_q.pins_q;
  assign sys_clk_en = s_q.en_q;
  assign port_a_bit6_pin_out = s_q.out_q;
  assign port_a_bit6_pin_oe = s_q.oe_q;
  assign mode_valid = s_q.taken_q;
endmodule : oms_select
`default_nettype wire

/* test/oms_chk.sv */
// checker: decode, pin ownership, clock out timing
// assumes bind onto oms_select ports
`timescale 1ns/100ps
`default_nettype none
module oms_chk (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [2:0] osc_mode_select_bits,
  input wire oms_pkg::oms_mode_type mode,
  input wire oms_pkg::oms_src_type clk_source,
  input wire oms_pkg::oms_pins_type pins,
  input wire logic sys_clk_en,
  input wire logic port_a_bit6_pin_out,
  input wire logic port_a_bit6_pin_oe,
  input wire logic mode_valid
);
  import oms_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  wire logic v = mode_valid;
  wire logic [2:0] m = mode;
  wire logic o = port_a_bit6_pin_out;
  sequence s_low2; ##1 o ##1 !o [*2] ##1 o; endsequence
  property p_cap; $rose(v) |-> m == $past(osc_mode_select_bits); endproperty
  a_cap: assert property (p_cap) else $error("capture");
  property p_xt; v && m < 3'h3 |-> pins.osc_in_reserved && pins.osc_out_reserved && !pins.bit6_gpio; endproperty
  a_xt: assert property (p_xt) else $error("crystal pins");
  property p_rc; v && m == 3'h7 && $rose(o) |-> o ##0 s_low2; endproperty
  a_rc: assert property (p_rc) else $error("rc clock out");
  property p_rio; v && m == 3'h6 |-> pins.bit6_gpio && !o; endproperty
  a_rio: assert property (p_rio) else $error("rc io");
  property p_ick; v && m == 3'h5 |-> pins.bit6_clkout && pins.bit7_gpio; endproperty
  a_ick: assert property (p_ick) else $error("int clock out");
  property p_iio; v && m == 3'h4 |-> pins.bit6_gpio && pins.bit7_gpio && !o; endproperty
  a_iio: assert property (p_iio) else $error("int io");
  property p_ext; v && m == 3'h3 |-> pins.bit6_gpio && clk_source == oms_src_external; endproperty
  a_ext: assert property (p_ext) else $error("ext clock");
  property p_int; v && clk_source == oms_src_internal && sys_clk_en |-> ##15 sys_clk_en; endproperty
  a_int: assert property (p_int) else $error("int tick");
  property p_stat; v |=> v && $stable(m); endproperty
  a_stat: assert property (p_stat) else $error("mode moved");
  property p_oe; v |=> port_a_bit6_pin_oe == (m == 3'h5 || m == 3'h7); endproperty
  a_oe: assert property (p_oe) else $error("bit6 drive");
endmodule : oms_chk
bind oms_select oms_chk chk (.clock, .arst_n, .osc_mode_select_bits, .mode, .clk_source, .pins, .sys_clk_en,
  .port_a_bit6_pin_out, .port_a_bit6_pin_oe, .mode_valid);
`default_nettype wire

/* test/oms_ext_clk.sv */
// far side: external clock source on the oscillator input
// assumes run is high only in external clock mode
`timescale 1ns/100ps
`default_nettype none
module oms_ext_clk (
  input wire logic clock,
  input wire logic run,
  output wire logic osc_in_pin
);
  logic [1:0] cnt_q = 2'h0;
  always @(posedge clock) cnt_q <= cnt_q + 2'h1;
  // still low outside runs; resonators past 3.5 MHz belong in high-speed
  assign osc_in_pin = run & cnt_q[1];
endmodule : oms_ext_clk
`default_nettype wire

/* test/tb.sv */
// bench: every mode code, captured decode, strap noise after capture
// assumes oms_select, oms_ext_clk and checker compiled
`timescale 1ns/100ps
`default_nettype none
module tb;
  import oms_pkg::*;
  logic clock = 0, arst_n = 0, run = 0, seen = 0, ce, b6o, b6e, vld;
  logic probe = 0, any_ce = 0, any_rise = 0, b6o_prev = 0;
  logic [2:0] pin_notes[$];
  logic [2:0] strap = 3'h0;
  wire logic osc;
  oms_mode_type mode;
  oms_src_type src;
  oms_pins_type pins;
  logic [9:0] notes[$];
  logic [6:0] tbl[8] = '{7'h18, 7'h18, 7'h18, 7'h74, 7'h46, 7'h43, 7'h34, 7'h31};
  int n_mismatch = 0, checks_done = 0, seed = 32'h6030;
  oms_select DUT (.clock, .arst_n, .osc_mode_select_bits(strap), .osc_in_pin(osc), .mode, .clk_source(src),
    .pins, .sys_clk_en(ce), .port_a_bit6_pin_out(b6o), .port_a_bit6_pin_oe(b6e), .mode_valid(vld));
  oms_ext_clk ext (.clock, .run, .osc_in_pin(osc));
  initial forever #4 clock = ~clock;
  task automatic cmp(logic [9:0] got, logic [9:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic cmp_pin(logic [2:0] got, logic [2:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_pin
  task automatic finish_test;
    if (n_mismatch == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test
  always @(posedge clock) begin
    if (vld && !seen) cmp({mode, src, pins}, notes.pop_front());
    if (probe) cmp_pin({b6e, any_ce, any_rise}, pin_notes.pop_front());
    any_ce <= arst_n && (any_ce || ce);
    any_rise <= arst_n && (any_rise || (b6o && !b6o_prev));
    b6o_prev <= b6o;
    seen <= vld;
  end
  initial begin
    for (int c = 0; c < 8; c++) begin
      @(posedge clock);
      arst_n <= 0;
      strap <= c[2:0];
      run <= (c == 3);
      repeat (16) @(posedge clock);
      notes.push_back({c[2:0], tbl[c]});
      arst_n <= 1;
      repeat (80) begin
        @(posedge clock);
        if (vld) strap <= 3'($random(seed));
      end
      pin_notes.push_back({(c == 5 || c == 7), 1'b1, (c == 5 || c == 7)});
      probe <= 1;
      @(posedge clock);
      probe <= 0;
    end
    @(posedge clock);
    finish_test();
  end
  initial begin
    #50000;
    n_mismatch++;
    finish_test();
  end
endmodule : tb
`default_nettype wire
